/* sqo_pkg.sv */
// subtract-one and quotient unit: shared constants, opcodes and types
// assumes one decoded opcode at a time from the core's instruction decoder
//
// Contract
// - subtract-one wraps 00h to ffh, nothing else
// - subtract-one never touches any status flag
// - four sources: acc, register, direct, indirect
// - port targets read output latch, not pins
// - acc form: opcode 14h, one machine cycle
// - register form: 00011rrr, one machine cycle
// - direct form: 15h plus address, one cycle
// - indirect form: 0001011i picks pointer, one cycle
// - quotient: acc/secondary, quotient acc, remainder secondary
// - nonzero divisor clears carry and overflow
// - zero divisor sets overflow, results undefined
// - quotient always clears carry
// - quotient opcode 84h, four machine cycles
package sqo_pkg;

  // timing in machine cycles, each of MC_CLKS_DEF core clocks by default
  localparam int unsigned MC_CLKS_DEF = 8;   // core clocks per machine cycle
  localparam int unsigned MC_DEC      = 1;   // subtract-one length
  localparam int unsigned MC_DIV      = 4;   // quotient length
  localparam int          CNT_W       = 8;   // width of the retire counter

  // opcodes and opcode families
  localparam logic [7:0] OPC_DEC_ACC = 8'h14;  // accumulator form
  localparam logic [7:0] OPC_DEC_DIR = 8'h15;  // direct form, address follows
  localparam logic [6:0] OPC_DEC_IND = 7'h0b;  // upper seven bits, low bit = pointer
  localparam logic [4:0] OPC_DEC_REG = 5'h03;  // upper five bits, low three = register
  localparam logic [7:0] OPC_DIV     = 8'h84;  // quotient form

  // data constants
  localparam int         DIV_W     = 8;      // operand width of the divider
  localparam logic [7:0] BYTE_ONE  = 8'h01;  // decrement step
  localparam logic [7:0] BYTE_ZERO = 8'h00;  // zero divisor / reset value
  localparam logic [2:0] BANK_PAD  = 3'h0;   // top bits of a working register address
  localparam logic [1:0] PTR_PAD   = 2'h0;   // pad between bank and pointer select

  // decoded operation kinds
  typedef enum logic [2:0] {
    OP_NONE,
    OP_DEC_ACC,
    OP_DEC_REG,
    OP_DEC_DIR,
    OP_DEC_IND,
    OP_DIV
  } sqo_op_t;

  // sequencer states of the top
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_WAIT,
    ST_RD_TAKE,
    ST_HOLD
  } sqo_state_t;

endpackage : sqo_pkg

/* sqo_decode.sv */
// opcode classifier for the subtract-one and quotient groups
// assumes a same-clock opcode byte; purely combinational
`timescale 1ns/1ps
module sqo_decode (
  input  wire logic [7:0]      i_opcode,  // opcode byte from the decoder
  output sqo_pkg::sqo_op_t     o_op,      // operation kind, OP_NONE if foreign
  output logic [2:0]           o_sel      // register or pointer select bits
);
  import sqo_pkg::*;

  // map one opcode to its operation kind
  function automatic sqo_op_t classify(input logic [7:0] opc);
    sqo_op_t k;
    k = OP_NONE;                                            // anything else is not ours
    if (opc == OPC_DEC_ACC) k = OP_DEC_ACC;
    else if (opc == OPC_DEC_DIR) k = OP_DEC_DIR;
    else if (opc[7:1] == OPC_DEC_IND) k = OP_DEC_IND;
    else if (opc[7:3] == OPC_DEC_REG) k = OP_DEC_REG;
    else if (opc == OPC_DIV) k = OP_DIV;
    return k;
  endfunction : classify

  // classification and select field
  always_comb begin
    o_op  = classify(i_opcode);
    o_sel = i_opcode[2:0];  // rrr, or i in bit 0
  end

endmodule : sqo_decode

/* sqo_div.sv */
// iterative restoring divider, one quotient bit per clock
// assumes start only while idle; operands held inside from start onward
`timescale 1ns/1ps
module sqo_div #(
  parameter int W = sqo_pkg::DIV_W  // operand width
) (
  input  wire logic         i_clk,       // core clock
  input  wire logic         i_rst,       // synchronous, active high
  input  wire logic         i_start,     // one-cycle start pulse
  input  wire logic [W-1:0] i_dividend,  // unsigned dividend
  input  wire logic [W-1:0] i_divisor,   // unsigned divisor, zero allowed
  output logic              o_busy,      // high while bits are produced
  output logic [W-1:0]      o_quot,      // quotient, valid once busy falls
  output logic [W-1:0]      o_rem        // remainder, valid once busy falls
);
  import sqo_pkg::*;

  localparam int SW = $clog2(W + 1);  // step counter width

  // whole state of the divider
  typedef struct packed {
    logic          busy;  // iterating
    logic [SW-1:0] step;  // bits done so far
    logic [W-1:0]  dvs;   // divisor copy
    logic [W-1:0]  rem;   // partial remainder
    logic [W-1:0]  quo;   // dividend shifting out, quotient shifting in
  } sqo_div_st_t;

  sqo_div_st_t s_q;  // registered state
  sqo_div_st_t s_d;  // next state
  logic [W:0]  trial;  // remainder with next dividend bit appended

  // one restoring step per clock; a zero divisor always subtracts, so
  // the result is all ones with the dividend as remainder, never x
  always_comb begin
    s_d   = s_q;
    trial = {s_q.rem, s_q.quo[W-1]};
    if (i_start) begin  // load operands
      s_d.busy = 1'b1;
      s_d.step = '0;
      s_d.dvs  = i_divisor;
      s_d.rem  = '0;
      s_d.quo  = i_dividend;
    end else if (s_q.busy) begin  // produce one bit
      if (trial >= {1'b0, s_q.dvs}) begin  // fits: subtract, bit is one
        s_d.rem = W'(trial - {1'b0, s_q.dvs});
        s_d.quo = {s_q.quo[W-2:0], 1'b1};
      end else begin  // does not fit: keep, bit is zero
        s_d.rem = trial[W-1:0];
        s_d.quo = {s_q.quo[W-2:0], 1'b0};
      end
      s_d.step = s_q.step + 1'b1;
      if (s_q.step == SW'(W - 1)) begin  // last bit
        s_d.busy = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_busy = s_q.busy;
  assign o_quot = s_q.quo;
  assign o_rem  = s_q.rem;

endmodule : sqo_div

/* sqo_unit.sv */
// subtract-one and quotient execution unit of the core
// assumes a register/memory file on the same clock that returns read
// data one clock after a read strobe, and a decoder that presents one
// opcode per issue pulse together with its second byte
`timescale 1ns/1ps
module sqo_unit #(
  parameter int unsigned MC_CLKS = sqo_pkg::MC_CLKS_DEF  // clocks per machine cycle, >= 6
) (
  input  wire logic       I_MCLK,          // core clock, 200 MHz
  input  wire logic       I_RST,           // synchronous, active high
  input  wire logic       I_ISSUE,         // one-cycle instruction issue
  input  wire logic [7:0] I_OPCODE,        // opcode byte
  input  wire logic [7:0] I_OPERAND,       // second byte (direct address)
  input  wire logic [1:0] I_BANK,          // active working register bank
  input  wire logic [7:0] I_ACC,           // accumulator value at issue
  input  wire logic [7:0] I_B,             // secondary operand register at issue
  input  wire logic [7:0] I_MEM_RDATA,     // read data, one clock after read
  output logic            O_BUSY,          // instruction in flight
  output logic            O_DONE,          // one-cycle retire pulse
  output logic            O_REJECT,        // one-cycle refusal pulse
  output logic            O_MEM_RD,        // read strobe
  output logic [7:0]      O_MEM_ADDR,      // read/write address
  output logic            O_MEM_LATCH,     // ports answer from output latch
  output logic            O_MEM_INDIRECT,  // address is in indirect space
  output logic            O_MEM_WR,        // write strobe
  output logic [7:0]      O_MEM_WDATA,     // write data
  output logic            O_ACC_WR,        // accumulator write strobe
  output logic [7:0]      O_ACC_WDATA,     // accumulator write data
  output logic            O_B_WR,          // secondary register write strobe
  output logic [7:0]      O_B_WDATA,       // secondary register write data
  output logic            O_FLAG_WR,       // carry/overflow write strobe
  output logic            O_CY,            // carry value to write
  output logic            O_OV             // overflow_flag value to write
);
  import sqo_pkg::*;

  // retire points, counted in core clocks from the taking edge
  localparam logic [CNT_W-1:0] LIM_DEC = CNT_W'(MC_DEC * MC_CLKS);
  localparam logic [CNT_W-1:0] LIM_DIV = CNT_W'(MC_DIV * MC_CLKS);

  // whole state of the unit
  typedef struct packed {
    sqo_state_t       st;         // sequencer state
    sqo_op_t          op;         // operation in flight
    logic             ptr_phase;  // next read data is a pointer
    logic [CNT_W-1:0] cnt;        // clocks since the taking edge
    logic [CNT_W-1:0] lim;        // retire count for this operation
    logic [7:0]       opa;        // captured accumulator
    logic [7:0]       opb;        // captured secondary register
    logic             dvz;        // captured divisor was zero
    logic             div_go;     // divider start pulse
    logic             busy;       // drives O_BUSY
    logic             done;       // drives O_DONE
    logic             reject;     // drives O_REJECT
    logic             mem_rd;     // drives O_MEM_RD
    logic [7:0]       mem_addr;   // drives O_MEM_ADDR
    logic             mem_latch;  // drives O_MEM_LATCH
    logic             mem_ind;    // drives O_MEM_INDIRECT
    logic             mem_wr;     // drives O_MEM_WR
    logic [7:0]       mem_wdata;  // drives O_MEM_WDATA
    logic             acc_wr;     // drives O_ACC_WR
    logic [7:0]       acc_wdata;  // drives O_ACC_WDATA
    logic             b_wr;       // drives O_B_WR
    logic [7:0]       b_wdata;    // drives O_B_WDATA
    logic             flag_wr;    // drives O_FLAG_WR
    logic             cy;         // drives O_CY
    logic             ov;         // drives O_OV
  } sqo_unit_st_t;

  sqo_unit_st_t s_q;  // registered state
  sqo_unit_st_t s_d;  // next state

  sqo_op_t    dec_op;    // kind of the presented opcode
  logic [2:0] dec_sel;   // register or pointer select
  logic       div_busy;  // divider still iterating
  logic [7:0] div_quot;  // divider quotient
  logic [7:0] div_rem;   // divider remainder

  // opcode classification
  sqo_decode u_decode (
    .i_opcode (I_OPCODE),
    .o_op     (dec_op),
    .o_sel    (dec_sel)
  );

  // quotient datapath; eight clocks fit well inside four machine cycles
  sqo_div #(
    .W (DIV_W)
  ) u_div (
    .i_clk      (I_MCLK),
    .i_rst      (I_RST),
    .i_start    (s_q.div_go),
    .i_dividend (s_q.opa),
    .i_divisor  (s_q.opb),
    .o_busy     (div_busy),
    .o_quot     (div_quot),
    .o_rem      (div_rem)
  );

  // sequencer: take, fetch operand, write back, retire on the count
  always_comb begin
    s_d = s_q;
    // strobes last one clock
    s_d.div_go  = 1'b0;
    s_d.done    = 1'b0;
    s_d.reject  = 1'b0;
    s_d.mem_rd  = 1'b0;
    s_d.mem_wr  = 1'b0;
    s_d.acc_wr  = 1'b0;
    s_d.b_wr    = 1'b0;
    s_d.flag_wr = 1'b0;
    // machine-cycle clock count runs only while in flight
    if (s_q.busy) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
    // refuse an issue that arrives while another is in flight
    if (I_ISSUE && (s_q.st != ST_IDLE)) begin
      s_d.reject = 1'b1;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        if (I_ISSUE) begin
          if (dec_op == OP_NONE) begin  // not an opcode of this unit
            s_d.reject = 1'b1;
          end else begin  // take it
            s_d.busy      = 1'b1;
            s_d.cnt       = {{(CNT_W-1){1'b0}}, 1'b1};
            s_d.op        = dec_op;
            s_d.st        = ST_HOLD;
            s_d.ptr_phase = 1'b0;
            s_d.opa       = I_ACC;
            s_d.opb       = I_B;
            s_d.dvz       = (I_B == BYTE_ZERO);
            s_d.lim       = (dec_op == OP_DIV) ? LIM_DIV : LIM_DEC;
            unique case (dec_op)
              OP_DEC_ACC: begin  // result waits for the retire edge
                s_d.acc_wdata = I_ACC - BYTE_ONE;
              end
              OP_DEC_REG: begin  // read the selected working register
                s_d.mem_rd    = 1'b1;
                s_d.mem_addr  = {BANK_PAD, I_BANK, dec_sel};
                s_d.mem_latch = 1'b1;
                s_d.mem_ind   = 1'b0;
                s_d.st        = ST_RD_WAIT;
              end
              OP_DEC_DIR: begin  // read the direct byte
                s_d.mem_rd    = 1'b1;
                s_d.mem_addr  = I_OPERAND;
                s_d.mem_latch = 1'b1;
                s_d.mem_ind   = 1'b0;
                s_d.st        = ST_RD_WAIT;
              end
              OP_DEC_IND: begin  // read the pointer register first
                s_d.mem_rd    = 1'b1;
                s_d.mem_addr  = {BANK_PAD, I_BANK, PTR_PAD, dec_sel[0]};
                s_d.mem_latch = 1'b1;
                s_d.mem_ind   = 1'b0;
                s_d.ptr_phase = 1'b1;
                s_d.st        = ST_RD_WAIT;
              end
              OP_DIV: begin  // divider loads captured operands next clock
                s_d.div_go = 1'b1;
              end
              OP_NONE: begin  // handled above
              end
            endcase
          end
        end
      end
      ST_RD_WAIT: begin  // file answers one clock after the strobe
        s_d.st = ST_RD_TAKE;
      end
      ST_RD_TAKE: begin
        if (s_q.ptr_phase) begin  // pointer arrived: read the target byte
          s_d.mem_rd    = 1'b1;
          s_d.mem_addr  = I_MEM_RDATA;
          s_d.mem_latch = 1'b1;
          s_d.mem_ind   = 1'b1;
          s_d.ptr_phase = 1'b0;
          s_d.st        = ST_RD_WAIT;
        end else begin  // operand arrived: write it back one lower
          s_d.mem_wr    = 1'b1;
          s_d.mem_wdata = I_MEM_RDATA - BYTE_ONE;
          s_d.st        = ST_HOLD;
        end
      end
      ST_HOLD: begin  // wait out the machine cycles, then retire
        if (s_q.cnt == s_q.lim) begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.st   = ST_IDLE;
          if (s_q.op == OP_DEC_ACC) begin
            s_d.acc_wr = 1'b1;
          end
          // subtract-one never raises the flag strobe, so every flag stays
          if (s_q.op == OP_DIV) begin
            s_d.acc_wr    = 1'b1;
            s_d.acc_wdata = div_quot;
            s_d.b_wr      = 1'b1;
            s_d.b_wdata   = div_rem;
            s_d.flag_wr   = 1'b1;
            s_d.cy        = 1'b0;
            s_d.ov        = s_q.dvz;
          end
        end
      end
    endcase
  end

  // state register; a zero divisor follows the same count, so the
  // instruction length never depends on the operands
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign O_BUSY         = s_q.busy;
  assign O_DONE         = s_q.done;
  assign O_REJECT       = s_q.reject;
  assign O_MEM_RD       = s_q.mem_rd;
  assign O_MEM_ADDR     = s_q.mem_addr;
  assign O_MEM_LATCH    = s_q.mem_latch;
  assign O_MEM_INDIRECT = s_q.mem_ind;
  assign O_MEM_WR       = s_q.mem_wr;
  assign O_MEM_WDATA    = s_q.mem_wdata;
  assign O_ACC_WR       = s_q.acc_wr;
  assign O_ACC_WDATA    = s_q.acc_wdata;
  assign O_B_WR         = s_q.b_wr;
  assign O_B_WDATA      = s_q.b_wdata;
  assign O_FLAG_WR      = s_q.flag_wr;
  assign O_CY           = s_q.cy;
  assign O_OV           = s_q.ov;

  // divider busy is kept for visibility in waveforms only through div_quot
  // timing; the retire count already covers its eight clocks
  logic unused_div_busy;  // deliberately unread status
  assign unused_div_busy = div_busy;

endmodule : sqo_unit

/* sqo_mem_model.sv */
// behavioural register/memory file facing the subtract-one and quotient unit
// assumes read data is wanted exactly one clock after the read strobe
`timescale 1ns/1ps
module sqo_mem_model (
  input  wire logic       i_clk,    // core clock
  input  wire logic       i_rd,     // read strobe from the unit
  input  wire logic [7:0] i_addr,   // read/write address
  input  wire logic       i_wr,     // write strobe from the unit
  input  wire logic [7:0] i_wdata,  // write data
  output logic [7:0]      o_rdata   // read data, driven one clock after read
);
  logic [7:0] mem [256];       // one flat space; ports hold their output latch here
  logic       rd_q;            // read was strobed last clock
  logic [7:0] addr_q;          // address of that read
  logic [7:0] last_q = 8'h00;  // last value put on the bus

  // capture strobes and store writes
  always @(posedge i_clk) begin
    rd_q   <= i_rd;
    addr_q <= i_addr;
    if (rd_q) begin
      last_q <= mem[addr_q];
    end
    if (i_wr) begin
      mem[i_addr] <= i_wdata;
    end
  end

  // stored latch value answers every read; released bus shows the inverse
  assign o_rdata = rd_q ? mem[addr_q] : ~last_q;
endmodule : sqo_mem_model

/* sqo_unit_asserts.sv */
// timing and result checks at the ports of the subtract-one and quotient unit
// assumes one clock domain and the issue contract of the unit
`timescale 1ns/1ps
module sqo_unit_asserts #(
  parameter int unsigned MC_CLKS = sqo_pkg::MC_CLKS_DEF  // clocks per machine cycle
) (
  input wire logic       I_MCLK,
  input wire logic       I_RST,
  input wire logic       I_ISSUE,
  input wire logic [7:0] I_OPCODE,
  input wire logic [7:0] I_OPERAND,
  input wire logic [1:0] I_BANK,
  input wire logic [7:0] I_ACC,
  input wire logic [7:0] I_B,
  input wire logic [7:0] I_MEM_RDATA,
  input wire logic       O_BUSY,
  input wire logic       O_DONE,
  input wire logic       O_REJECT,
  input wire logic       O_MEM_RD,
  input wire logic [7:0] O_MEM_ADDR,
  input wire logic       O_MEM_LATCH,
  input wire logic       O_MEM_INDIRECT,
  input wire logic       O_MEM_WR,
  input wire logic [7:0] O_MEM_WDATA,
  input wire logic       O_ACC_WR,
  input wire logic [7:0] O_ACC_WDATA,
  input wire logic       O_B_WR,
  input wire logic [7:0] O_B_WDATA,
  input wire logic       O_FLAG_WR,
  input wire logic       O_CY,
  input wire logic       O_OV
);
  import sqo_pkg::*;
  logic        known, take, take_rd, take_ind;  // decoded issue events
  logic        run_q, div_q, acc_q_form;        // instruction in flight and its kind
  int unsigned cnt_q, len_q;                    // clocks since take, expected length
  logic [7:0]  acc_q, b_q, addr_q;              // operands seen at take

  // legal opcodes; anything else is refused
  assign known = I_OPCODE inside {OPC_DEC_ACC, OPC_DEC_DIR, OPC_DIV} ||
                 I_OPCODE[7:1] == OPC_DEC_IND || I_OPCODE[7:3] == OPC_DEC_REG;
  assign take     = I_ISSUE && !O_BUSY && known;
  assign take_rd  = take && (I_OPCODE == OPC_DEC_DIR || I_OPCODE[7:3] == OPC_DEC_REG);
  assign take_ind = take && I_OPCODE[7:1] == OPC_DEC_IND;

  // shadow of the in-flight instruction, counted in clocks
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      run_q <= 1'b0;
      cnt_q <= 0;
    end else if (take) begin
      run_q      <= 1'b1;
      cnt_q      <= 0;
      len_q      <= (I_OPCODE == OPC_DIV) ? MC_DIV * MC_CLKS : MC_DEC * MC_CLKS;
      div_q      <= I_OPCODE == OPC_DIV;
      acc_q_form <= I_OPCODE == OPC_DEC_ACC;
      acc_q      <= I_ACC;
      b_q        <= I_B;
      addr_q     <= I_OPCODE[7:1] == OPC_DEC_IND ? {BANK_PAD, I_BANK, PTR_PAD, I_OPCODE[0]} :
                    I_OPCODE == OPC_DEC_DIR ? I_OPERAND : {BANK_PAD, I_BANK, I_OPCODE[2:0]};
    end else if (run_q) begin
      run_q <= cnt_q != len_q;
      cnt_q <= cnt_q + 1;
    end
  end

  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  // read with latch, idle clock, then write of read value minus one
  sequence s_rmw;
    O_MEM_RD && O_MEM_LATCH ##1 !O_MEM_RD ##1 O_MEM_WR && O_MEM_WDATA == $past(I_MEM_RDATA) - 8'h01;
  endsequence

  chk_done_time: assert property ((run_q && cnt_q == len_q) == O_DONE)
    else $error("retire pulse at wrong clock");
  chk_busy_span: assert property (O_BUSY == (run_q && cnt_q < len_q))
    else $error("busy level out of span");
  chk_flag_div: assert property (O_FLAG_WR == (O_DONE && div_q))
    else $error("flag strobe outside quotient retire");
  chk_cy_ov: assert property (O_FLAG_WR |-> !O_CY && O_OV == (b_q == 8'h00))
    else $error("carry or overflow value wrong");
  chk_div_res: assert property (O_DONE && div_q && b_q != 8'h00 |->
      O_ACC_WR && O_B_WR && O_ACC_WDATA == acc_q / b_q && O_B_WDATA == acc_q % b_q)
    else $error("quotient or remainder wrong");
  chk_acc_dec: assert property (O_DONE && acc_q_form |-> O_ACC_WR && O_ACC_WDATA == acc_q - 8'h01)
    else $error("accumulator decrement wrong");
  chk_reject_pulse: assert property (I_ISSUE && !take |=> O_REJECT)
    else $error("refused issue without reject pulse");
  chk_rd_rmw: assert property (take_rd |=> O_MEM_ADDR == addr_q && !O_MEM_INDIRECT ##0 s_rmw)
    else $error("direct or register update wrong");
  chk_ind_chain: assert property (take_ind |=> O_MEM_RD && O_MEM_ADDR == addr_q ##2
      O_MEM_INDIRECT && O_MEM_ADDR == $past(I_MEM_RDATA) ##0 s_rmw)
    else $error("indirect update wrong");
endmodule : sqo_unit_asserts

bind sqo_unit sqo_unit_asserts #(.MC_CLKS(MC_CLKS)) u_chk (
  .I_MCLK(I_MCLK), .I_RST(I_RST), .I_ISSUE(I_ISSUE), .I_OPCODE(I_OPCODE),
  .I_OPERAND(I_OPERAND), .I_BANK(I_BANK), .I_ACC(I_ACC), .I_B(I_B),
  .I_MEM_RDATA(I_MEM_RDATA), .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_REJECT(O_REJECT),
  .O_MEM_RD(O_MEM_RD), .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_LATCH(O_MEM_LATCH),
  .O_MEM_INDIRECT(O_MEM_INDIRECT), .O_MEM_WR(O_MEM_WR), .O_MEM_WDATA(O_MEM_WDATA),
  .O_ACC_WR(O_ACC_WR), .O_ACC_WDATA(O_ACC_WDATA), .O_B_WR(O_B_WR), .O_B_WDATA(O_B_WDATA),
  .O_FLAG_WR(O_FLAG_WR), .O_CY(O_CY), .O_OV(O_OV));

/* sqo_unit_tb.sv */
// self-checking bench for the subtract-one and quotient unit
// assumes the memory model answers reads one clock late; short machine cycle
`timescale 1ns/1ps
module sqo_unit_tb;
  import sqo_pkg::*;
  localparam int unsigned MC = 6;  // smallest legal machine cycle, keeps the run short
  localparam logic [3:0] K_MEM = 4'h1, K_ACC = 4'h2, K_B = 4'h3, K_FLG = 4'h4, K_REJ = 4'h5;
  logic I_MCLK = 1'b0, I_RST = 1'b1, I_ISSUE = 1'b0;
  logic [7:0] I_OPCODE = 8'h00, I_OPERAND = 8'h00, I_ACC = 8'h00, I_B = 8'h00, I_MEM_RDATA;
  logic [1:0] I_BANK = 2'h0;
  logic O_BUSY, O_DONE, O_REJECT, O_MEM_RD, O_MEM_LATCH, O_MEM_INDIRECT, O_MEM_WR;
  logic O_ACC_WR, O_B_WR, O_FLAG_WR, O_CY, O_OV;
  logic [7:0] O_MEM_ADDR, O_MEM_WDATA, O_ACC_WDATA, O_B_WDATA;
  logic [19:0] exp_q [$];          // expected results, oldest first
  int fails = 0, n_tests = 0;
  logic [31:0] seed = 32'h3593;    // fixed xorshift seed

  always #2.5 I_MCLK = ~I_MCLK;    // 200 MHz

  sqo_unit #(.MC_CLKS(MC)) i_dut (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_ISSUE(I_ISSUE),
    .I_OPCODE(I_OPCODE), .I_OPERAND(I_OPERAND), .I_BANK(I_BANK), .I_ACC(I_ACC), .I_B(I_B),
    .I_MEM_RDATA(I_MEM_RDATA), .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_REJECT(O_REJECT),
    .O_MEM_RD(O_MEM_RD), .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_LATCH(O_MEM_LATCH),
    .O_MEM_INDIRECT(O_MEM_INDIRECT), .O_MEM_WR(O_MEM_WR), .O_MEM_WDATA(O_MEM_WDATA),
    .O_ACC_WR(O_ACC_WR), .O_ACC_WDATA(O_ACC_WDATA), .O_B_WR(O_B_WR), .O_B_WDATA(O_B_WDATA),
    .O_FLAG_WR(O_FLAG_WR), .O_CY(O_CY), .O_OV(O_OV));
  sqo_mem_model i_mem (.i_clk(I_MCLK), .i_rd(O_MEM_RD), .i_addr(O_MEM_ADDR), .i_wr(O_MEM_WR),
    .i_wdata(O_MEM_WDATA), .o_rdata(I_MEM_RDATA));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic end_of_test();
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [19:0] e, input logic [19:0] g);
    n_tests++;
    if (e !== g) begin
      fails++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp

  // oldest note against what just appeared; an unexpected event never matches
  task automatic take_note(input logic [19:0] g);
    logic [19:0] e;
    e = (exp_q.size() != 0) ? exp_q.pop_front() : 20'hfffff;
    cmp(e, g);
  endtask : take_note

  task automatic push(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d);
    exp_q.push_back({k, a, d});
  endtask : push

  // one-cycle issue, launched at a rising edge
  task automatic iss(input logic [7:0] op, input logic [1:0] bk, input logic [7:0] a,
                     input logic [7:0] b);
    @(posedge I_MCLK);
    I_ISSUE   <= 1'b1;
    I_OPCODE  <= op;
    I_OPERAND <= rnd();
    I_BANK    <= bk;
    I_ACC     <= a;
    I_B       <= b;
    @(posedge I_MCLK);
    I_ISSUE   <= 1'b0;
  endtask : iss

  // wait for retire under a bound
  task automatic wait_done();
    int k;
    for (k = 0; k < 4 * MC + 8; k++) begin
      @(negedge I_MCLK);
      if (O_DONE === 1'b1) break;
    end
    if (k == 4 * MC + 8) fails++;
  endtask : wait_done

  // watch the result strobes, in a fixed order within one clock
  always @(negedge I_MCLK) begin
    if (!I_RST) begin
      if (O_MEM_WR !== 1'b0) take_note({K_MEM, O_MEM_ADDR, O_MEM_WDATA});
      if (O_ACC_WR !== 1'b0) take_note({K_ACC, 8'h00, O_ACC_WDATA});
      if (O_B_WR !== 1'b0) take_note({K_B, 8'h00, O_B_WDATA});
      if (O_FLAG_WR !== 1'b0) take_note({K_FLG, 8'h00, 6'h00, O_CY, O_OV});
      if (O_REJECT !== 1'b0) take_note({K_REJ, 16'h0000});
    end
  end

  // hang guard, far beyond the expected run
  initial begin
    #60000;
    fails++;
    end_of_test();
  end

  initial begin
    logic [7:0] a, b, v, ad, p;
    logic [1:0] bk;
    logic [7:0] da [8] = '{8'hfb, 8'h00, 8'hff, 8'h07, 8'h00, 8'h80, 8'h35, 8'h01};
    logic [7:0] db [8] = '{8'h12, 8'h05, 8'h01, 8'h00, 8'h00, 8'h03, 8'h35, 8'hff};
    repeat (5) @(posedge I_MCLK);
    I_RST <= 1'b0;
    // accumulator form, first one wraps
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 8'h00 : rnd();
      push(K_ACC, 8'h00, a - 8'h01);
      iss(OPC_DEC_ACC, rnd(), a, rnd());
      wait_done();
    end
    // every working register, random bank; direct form on random addresses
    for (int i = 0; i < 12; i++) begin
      bk = rnd();
      v  = (i == 0) ? 8'h00 : rnd();
      ad = {BANK_PAD, bk, i[2:0]};
      if (i < 8) i_mem.mem[ad] = v;
      push(K_MEM, ad, v - 8'h01);
      if (i < 8) iss({OPC_DEC_REG, i[2:0]}, bk, rnd(), rnd());
      else begin
        iss(OPC_DEC_DIR, bk, rnd(), rnd());
        ad = I_OPERAND;
        i_mem.mem[ad] = v;
        exp_q[exp_q.size() - 1] = {K_MEM, ad, v - 8'h01};
      end
      wait_done();
    end
    // indirect through both pointers
    for (int i = 0; i < 4; i++) begin
      bk = rnd();
      p  = {2'h1, 6'(rnd())};  // target above the register banks, never a pointer
      v  = (i == 1) ? 8'h00 : rnd();
      i_mem.mem[{BANK_PAD, bk, PTR_PAD, i[0]}] = p;
      i_mem.mem[p] = v;
      push(K_MEM, p, v - 8'h01);
      iss({OPC_DEC_IND, i[0]}, bk, rnd(), rnd());
      wait_done();
    end
    // quotient table, zero divisors included
    for (int i = 0; i < 12; i++) begin
      a = (i < 8) ? da[i] : rnd();
      b = (i < 8) ? db[i] : rnd();
      push(K_ACC, 8'h00, (b == 8'h00) ? 8'hff : a / b);
      push(K_B, 8'h00, (b == 8'h00) ? a : a % b);
      push(K_FLG, 8'h00, {7'h00, b == 8'h00});
      iss(OPC_DIV, rnd(), a, b);
      wait_done();
    end
    // foreign opcodes refused while idle
    for (int i = 0; i < 3; i++) begin
      push(K_REJ, 8'h00, 8'h00);
      iss((i == 0) ? 8'h13 : (i == 1) ? 8'h85 : 8'h04, rnd(), rnd(), rnd());
      repeat (3) @(negedge I_MCLK);
    end
    // issue while busy is refused, first instruction still retires
    a = rnd();
    push(K_REJ, 8'h00, 8'h00);
    push(K_ACC, 8'h00, a - 8'h01);
    iss(OPC_DEC_ACC, 2'h0, a, 8'h00);
    iss(OPC_DIV, 2'h0, a, 8'h01);
    wait_done();
    repeat (10) @(negedge I_MCLK);
    cmp(20'h00000, {12'h000, exp_q.size() == 0 ? 8'h00 : 8'hee});
    end_of_test();
  end
endmodule : sqo_unit_tb
